// >>> src/bsdc_top.sv
// Purpose: supervision, short protection, rails-good and voltage select for buck rails
// Assumes: analog sense levels are asynchronous; APB master on clk; srst synchronous
// Notes: rails 0..4 are converters 1..5, rails 0..2 are voltage-scaling capable
//
// Design decisions made here: the register addresses and the APB interface to the registers.
module bsdc_top #(
  parameter int QUAL_CYC = bsdc_pkg::QUAL_CYC,
  parameter int MASK_CYC = bsdc_pkg::MASK_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bsdc_pkg::bsdc_sense_t sense,
  input wire logic switch_sync_clock_in,
  input wire logic sleep_request_pin,
  input wire logic rail_enable_pin_a,
  input wire logic rail_enable_pin_b,
  input wire logic dual_phase,
  output logic [4:0] conv_on,
  output logic [4:0] lin_on,
  output logic [4:0] conv_clk_from_sync,
  output logic [7:0] sw_period,
  output logic sync_locked,
  output logic sink_limit_enable,
  output logic [2:0] load_monitor_select,
  output logic rails_good,
  output logic short_irq,
  output logic [2:0][6:0] voltage_code
);
  localparam int QW = $clog2(QUAL_CYC + 1);
  localparam int MW = $clog2(MASK_CYC + 1);
  localparam int SW = $clog2(bsdc_pkg::RAMP_STEP_CYC + 1);
  localparam int NS = $bits(bsdc_pkg::bsdc_sense_t) + 5;

  // Rails covered by a monitor selection; combined rail spans rails 0 and 1 (converters 1 and 2)
  function automatic logic [4:0] mon_rails(input logic [2:0] sel);
    case (sel)
      bsdc_pkg::MON_RAIL1: mon_rails = 5'h01;
      bsdc_pkg::MON_RAIL2: mon_rails = 5'h02;
      bsdc_pkg::MON_COMB: mon_rails = 5'h03;
      bsdc_pkg::MON_RAIL3: mon_rails = 5'h04;
      bsdc_pkg::MON_RAIL5: mon_rails = 5'h10;
      default: mon_rails = 5'h00;
    endcase
  endfunction : mon_rails

  // Two-stage synchroniser for every off-domain input
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {sense, switch_sync_clock_in, sleep_request_pin, rail_enable_pin_a,
                  rail_enable_pin_b, dual_phase};
      sync2_r <= sync1_r;
    end
  end

  bsdc_pkg::bsdc_sense_t sn;
  logic sync_clk_s;
  logic sleep_s;
  logic pin_a_s;
  logic pin_b_s;
  logic dual_s;
  assign {sn, sync_clk_s, sleep_s, pin_a_s, pin_b_s, dual_s} = sync2_r;

  // Register state
  logic [31:0] ctrl_r;
  logic [4:0] pg_mask_r;
  logic [2:0] mon_sel_r;
  logic [4:0] map_sleep_r;
  logic [4:0] map_a_r;
  logic [4:0] map_b_r;
  logic [2:0] rf_en_r;
  logic [2:0][6:0] prim_r;
  logic [2:0][7:0] sec_r;
  logic [4:0] lin_en_r;
  logic [4:0] conv_flag_r;
  logic [4:0] lin_flag_r;
  logic [31:0] rd_data;
  logic rd_hit;
  logic mask_active;

  logic setup_ph;
  logic access_done;
  logic wr_en;
  logic rd_done;
  assign setup_ph = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_en = access_done & pwrite & ~pslverr;
  assign rd_done = access_done & ~pwrite & ~pslverr;

  // Zero-wait slave: data and answer prepared in setup, valid through access
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      if (setup_ph) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= ~rd_hit;
      end
    end
  end

  // Software writes
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= bsdc_pkg::CTRL_RST;
      pg_mask_r <= bsdc_pkg::PG_MASK_RST;
      mon_sel_r <= bsdc_pkg::MON_NONE;
      map_sleep_r <= '0;
      map_a_r <= '0;
      map_b_r <= '0;
      rf_en_r <= '0;
      prim_r <= '0;
      sec_r <= '0;
      lin_en_r <= '0;
    end else if (wr_en) begin
      case (paddr)
        bsdc_pkg::OFS_CTRL: ctrl_r <= {17'h0_0000, pwdata[14:0]};
        bsdc_pkg::OFS_PG_MASK: pg_mask_r <= pwdata[4:0];
        bsdc_pkg::OFS_MON_SEL: mon_sel_r <= pwdata[2:0];
        bsdc_pkg::OFS_RAIL_MAP: begin
          map_sleep_r <= pwdata[4:0];
          map_a_r <= pwdata[bsdc_pkg::MAP_A_LSB +: 5];
          map_b_r <= pwdata[bsdc_pkg::MAP_B_LSB +: 5];
        end
        bsdc_pkg::OFS_DVS_CTRL: rf_en_r <= pwdata[2:0];
        bsdc_pkg::OFS_LIN_EN: lin_en_r <= pwdata[4:0];
        default: begin
          for (int d = 0; d < 3; d++) begin
            if (paddr == bsdc_pkg::OFS_PRIMARY0 + 8'(4 * d)) begin
              prim_r[d] <= pwdata[6:0];
            end
            if (paddr == bsdc_pkg::OFS_SECONDARY0 + 8'(4 * d)) begin
              sec_r[d] <= pwdata[7:0];
            end
          end
        end
      endcase
    end
  end

  // Read decode; unmapped offsets answer with an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      bsdc_pkg::OFS_CTRL: rd_data = ctrl_r;
      bsdc_pkg::OFS_PG_MASK: rd_data = {27'h000_0000, pg_mask_r};
      bsdc_pkg::OFS_MON_SEL: rd_data = {29'h0000_0000, mon_sel_r};
      bsdc_pkg::OFS_RAIL_MAP: rd_data = {11'h000, map_b_r, 3'h0, map_a_r, 3'h0, map_sleep_r};
      bsdc_pkg::OFS_DVS_CTRL: rd_data = {29'h0000_0000, rf_en_r};
      bsdc_pkg::OFS_CONV_SHORT: rd_data = {27'h000_0000, conv_flag_r};
      bsdc_pkg::OFS_LIN_SHORT: rd_data = {27'h000_0000, lin_flag_r};
      bsdc_pkg::OFS_THERMAL: rd_data = {27'h000_0000,
                                        sn.thermal & {5{ctrl_r[bsdc_pkg::CTRL_THERM_EN]}}};
      bsdc_pkg::OFS_STATUS: rd_data = {29'h0000_0000, mask_active, sync_locked, rails_good};
      bsdc_pkg::OFS_LIN_EN: rd_data = {27'h000_0000, lin_en_r};
      default: begin
        rd_hit = 1'b0;
        for (int d = 0; d < 3; d++) begin
          if (paddr == bsdc_pkg::OFS_PRIMARY0 + 8'(4 * d)) begin
            rd_data = {25'h000_0000, prim_r[d]};
            rd_hit = 1'b1;
          end
          if (paddr == bsdc_pkg::OFS_SECONDARY0 + 8'(4 * d)) begin
            rd_data = {24'h00_0000, sec_r[d]};
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  // Voltage-scaling target select and ramp for rails 0..2
  logic [2:0] dvs_off;
  logic [2:0] ramping;
  logic [2:0][6:0] cur_r;
  logic [2:0][SW-1:0] step_cnt_r;
  for (genvar d = 0; d < 3; d++) begin : g_dvs
    logic pin_act;
    logic assigned;
    logic use_sec;
    logic [6:0] target;
    assign pin_act = (map_sleep_r[d] & sleep_s) | (map_a_r[d] & pin_a_s) | (map_b_r[d] & pin_b_s);
    assign assigned = map_sleep_r[d] | map_a_r[d] | map_b_r[d];
    assign use_sec = (rf_en_r[d] & assigned) ? ~pin_act : sec_r[d][bsdc_pkg::SEC_CMD_BIT];
    assign target = use_sec ? sec_r[d][6:0] : prim_r[d];
    assign dvs_off[d] = (target == 7'h00);
    assign ramping[d] = (cur_r[d] != target) & ~dvs_off[d];

    // One code step per fixed interval toward the target
    always_ff @(posedge clk) begin
      if (srst) begin
        cur_r[d] <= '0;
        step_cnt_r[d] <= '0;
      end else if (!ramping[d]) begin
        step_cnt_r[d] <= '0;
      end else if (step_cnt_r[d] == SW'(bsdc_pkg::RAMP_STEP_CYC - 1)) begin
        step_cnt_r[d] <= '0;
        cur_r[d] <= (cur_r[d] < target) ? cur_r[d] + 7'h01 : cur_r[d] - 7'h01;
      end else begin
        step_cnt_r[d] <= step_cnt_r[d] + SW'(1);
      end
    end
  end

  // Rail enables: a set flag keeps the rail off until cleared
  logic [4:0] conv_req;
  logic [4:0] lin_req;
  assign conv_req = ctrl_r[bsdc_pkg::CTRL_CONV_EN_LSB +: 5] & ~conv_flag_r
                    & ~{2'b00, dvs_off};
  assign lin_req = lin_en_r & ~lin_flag_r;

  // Startup mask, restarted by device enable and by any rail turning on
  logic [MW-1:0] mask_cnt_r;
  logic rail_rise;
  assign rail_rise = |({conv_req, lin_req} & ~{conv_on, lin_on});
  assign mask_active = (mask_cnt_r != MW'(MASK_CYC));
  always_ff @(posedge clk) begin
    if (srst) begin
      mask_cnt_r <= '0;
    end else if (!sn.device_enable || rail_rise) begin
      mask_cnt_r <= '0;
    end else if (mask_active) begin
      mask_cnt_r <= mask_cnt_r + MW'(1);
    end
  end

  // Per-rail short qualification counters, converters then linear rails
  logic [9:0] short_det;
  logic [9:0] short_set;
  assign short_det = {sn.lin_short, sn.conv_short} & {lin_on, conv_on};
  for (genvar i = 0; i < 10; i++) begin : g_qual
    logic [QW-1:0] cnt_r;
    always_ff @(posedge clk) begin
      if (srst || !short_det[i]) begin
        cnt_r <= '0;
      end else if (cnt_r != QW'(QUAL_CYC)) begin
        cnt_r <= cnt_r + QW'(1);
      end
    end
    assign short_set[i] = short_det[i] & (cnt_r >= QW'(QUAL_CYC - 1)) & ~mask_active;
  end

  // Read clears only the bits that the read returned; a new set always wins
  logic rd_conv;
  logic rd_lin;
  assign rd_conv = rd_done & (paddr == bsdc_pkg::OFS_CONV_SHORT);
  assign rd_lin = rd_done & (paddr == bsdc_pkg::OFS_LIN_SHORT);
  always_ff @(posedge clk) begin
    if (srst) begin
      conv_flag_r <= '0;
      lin_flag_r <= '0;
    end else begin
      conv_flag_r <= (conv_flag_r & ~({5{rd_conv}} & prdata[4:0])) | short_set[4:0];
      lin_flag_r <= (lin_flag_r & ~({5{rd_lin}} & prdata[4:0])) | short_set[9:5];
    end
  end

  // Sync clock period measure with clamp and fallback
  logic sync_d_r;
  logic [7:0] per_cnt_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_d_r <= 1'b0;
      per_cnt_r <= '0;
      sw_period <= bsdc_pkg::FALLBACK_CYC;
      sync_locked <= 1'b0;
    end else begin
      sync_d_r <= sync_clk_s;
      if (sync_clk_s && !sync_d_r) begin
        per_cnt_r <= 8'h01;
        sync_locked <= 1'b1;
        if (per_cnt_r < bsdc_pkg::SAT_HI_CYC) begin
          sw_period <= bsdc_pkg::SAT_HI_CYC;
        end else if (per_cnt_r > bsdc_pkg::SAT_LO_CYC) begin
          sw_period <= bsdc_pkg::SAT_LO_CYC;
        end else begin
          sw_period <= per_cnt_r;
        end
      end else if (per_cnt_r >= bsdc_pkg::NOCLK_CYC) begin
        sync_locked <= 1'b0;
        sw_period <= bsdc_pkg::FALLBACK_CYC;
      end else begin
        per_cnt_r <= per_cnt_r + 8'h01;
      end
    end
  end

  // Rails-good: current check always, voltage check when both selected
  logic [4:0] mon_rails_sel;
  logic [4:0] forced;
  logic [4:0] rail_ok;
  logic [4:0] mask_eff;
  assign forced = ctrl_r[bsdc_pkg::CTRL_FORCED_LSB +: 5];
  assign mon_rails_sel = mon_rails(mon_sel_r);
  assign mask_eff = pg_mask_r | {3'b000, dual_s, 1'b0};
  for (genvar i = 0; i < 5; i++) begin : g_pg
    logic v_ok;
    logic adc_bad;
    assign v_ok = sn.conv_vgood[i] | (ramping[i % 3] & 1'(i < 3));
    assign adc_bad = ctrl_r[bsdc_pkg::CTRL_COMPMODE] & mon_rails_sel[i] & sn.adc_over_limit;
    assign rail_ok[i] = sn.conv_igood[i] & ~adc_bad
                        & (~ctrl_r[bsdc_pkg::CTRL_PG_BOTH] | v_ok);
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      conv_on <= '0;
      lin_on <= '0;
      conv_clk_from_sync <= '0;
      sink_limit_enable <= 1'b1;
      load_monitor_select <= bsdc_pkg::MON_NONE;
      rails_good <= 1'b0;
      short_irq <= 1'b0;
      voltage_code <= '0;
    end else begin
      conv_on <= conv_req;
      lin_on <= lin_req;
      conv_clk_from_sync <= forced;
      sink_limit_enable <= ctrl_r[bsdc_pkg::CTRL_SINK_LIM];
      // Monitoring is meaningful only with every covered rail in forced mode
      load_monitor_select <= ((mon_rails_sel != 5'h00) && ((mon_rails_sel & ~forced) == 5'h00))
                             ? mon_sel_r : bsdc_pkg::MON_NONE;
      rails_good <= &(rail_ok | mask_eff);
      short_irq <= (|{conv_flag_r, lin_flag_r}) & ~ctrl_r[bsdc_pkg::CTRL_IRQ_MASK];
      voltage_code <= cur_r;
    end
  end
endmodule : bsdc_top

// >>> src/bsdc_pkg.sv
// Purpose: shared constants and types for buck supervision and voltage-select control
// Assumes: 100 MHz system clock, APB register access with 8-bit byte addresses
// Notes: time figures are kept in their own unit and turned into cycle counts here
package bsdc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_KHZ = 100000;
  localparam int NCONV = 5;
  localparam int NLIN = 5;
  localparam int NDVS = 3;
  localparam int VW = 7;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PG_MASK = 8'h04;
  localparam logic [7:0] OFS_MON_SEL = 8'h08;
  localparam logic [7:0] OFS_RAIL_MAP = 8'h0c;
  localparam logic [7:0] OFS_DVS_CTRL = 8'h10;
  localparam logic [7:0] OFS_PRIMARY0 = 8'h14;
  localparam logic [7:0] OFS_SECONDARY0 = 8'h20;
  localparam logic [7:0] OFS_CONV_SHORT = 8'h2c;
  localparam logic [7:0] OFS_LIN_SHORT = 8'h30;
  localparam logic [7:0] OFS_THERMAL = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam logic [7:0] OFS_LIN_EN = 8'h3c;

  // Control, secondary and rail-map register field positions
  localparam int CTRL_CONV_EN_LSB = 0;
  localparam int CTRL_FORCED_LSB = 5;
  localparam int CTRL_SINK_LIM = 10;
  localparam int CTRL_THERM_EN = 11;
  localparam int CTRL_IRQ_MASK = 12;
  localparam int CTRL_PG_BOTH = 13;
  localparam int CTRL_COMPMODE = 14;
  localparam int SEC_CMD_BIT = 7;
  localparam int MAP_A_LSB = 8;
  localparam int MAP_B_LSB = 16;

  // Values after reset
  localparam logic [31:0] CTRL_RST = 32'h0000_2c00;
  localparam logic [4:0] PG_MASK_RST = 5'h1e;

  // Short qualification and startup mask, rounded up to whole cycles
  localparam int QUAL_MIN_NS = 155000;
  localparam int QUAL_CYC = (QUAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MASK_NS = 2000000;
  localparam int MASK_CYC = (MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Fixed ramp: one 10 mV code step at 2.5 mV/us
  localparam int RAMP_UV_PER_US = 2500;
  localparam int CODE_STEP_UV = 10000;
  localparam int RAMP_STEP_NS = CODE_STEP_UV * 1000 / RAMP_UV_PER_US;
  localparam int RAMP_STEP_CYC = RAMP_STEP_NS / CLK_PERIOD_NS;

  // Switching clock limits as periods in system cycles
  localparam int SAT_HI_KHZ = 2700;
  localparam int SAT_LO_KHZ = 1700;
  localparam int FALLBACK_KHZ = 2200;
  localparam logic [7:0] SAT_HI_CYC = 8'(CLK_KHZ / SAT_HI_KHZ);
  localparam logic [7:0] SAT_LO_CYC = 8'(CLK_KHZ / SAT_LO_KHZ);
  localparam logic [7:0] FALLBACK_CYC = 8'(CLK_KHZ / FALLBACK_KHZ);
  localparam logic [7:0] NOCLK_CYC = 8'(2 * (CLK_KHZ / SAT_LO_KHZ));

  typedef enum logic [2:0] {
    MON_NONE = 3'h0,
    MON_RAIL1 = 3'h1,
    MON_RAIL2 = 3'h2,
    MON_COMB = 3'h3,
    MON_RAIL3 = 3'h4,
    MON_RAIL5 = 3'h5
  } bsdc_mon_t;

  typedef struct packed {
    logic [NCONV-1:0] conv_short;
    logic [NLIN-1:0] lin_short;
    logic [NCONV-1:0] conv_vgood;
    logic [NCONV-1:0] conv_igood;
    logic [NCONV-1:0] thermal;
    logic adc_over_limit;
    logic device_enable;
  } bsdc_sense_t;
endpackage : bsdc_pkg

// >>> dv/bsdc_sync_src.sv
// Purpose: external sync clock source for the switching clock generator
// Assumes: half period given in system cycles, zero stops the source
// Notes: a stopped source rests low, so a lost clock is seen as silence
module bsdc_sync_src (
  input wire logic clk,
  input wire logic [7:0] half,
  output logic sync_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h00;
  initial sync_clk = 1'b0;
  // Toggle every half period; parked low while stopped
  always @(posedge clk) begin
    if (half == 8'h00) begin
      sync_clk <= 1'b0;
      cnt <= 8'h00;
    end else if (cnt + 8'h01 >= half) begin
      sync_clk <= ~sync_clk;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule : bsdc_sync_src

// >>> dv/bsdc_monitor.sv
// Purpose: concurrent checks on the supervision block ports
// Assumes: one clock, srst synchronous and active high
// Notes: ramp checks watch rail 0 only; helper counters saturate
module bsdc_monitor #(
  parameter int QUAL_CYC = bsdc_pkg::QUAL_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire bsdc_pkg::bsdc_sense_t sense,
  input wire logic [4:0] conv_on,
  input wire logic [4:0] lin_on,
  input wire logic [4:0] conv_clk_from_sync,
  input wire logic [7:0] sw_period,
  input wire logic sink_limit_enable,
  input wire logic [2:0] load_monitor_select,
  input wire logic rails_good,
  input wire logic short_irq,
  input wire logic [2:0][6:0] voltage_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ctrl_wr;
  logic [31:0] ctrl_w;
  int run;
  int gap;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  assign ctrl_wr = psel && penable && pready && pwrite && paddr == bsdc_pkg::OFS_CTRL;
  // Last control word accepted, for the delayed compares
  always_ff @(posedge clk) begin
    if (ctrl_wr) ctrl_w <= pwdata;
  end
  // Unbroken run of any short sense level
  always_ff @(posedge clk) begin
    if (srst || (sense.conv_short == 5'h00 && sense.lin_short == 5'h00)) run <= 0;
    else if (run < 1000) run <= run + 1;
  end
  // Cycles since the last step of rail 0, saturated so the first step passes
  always_ff @(posedge clk) begin
    if (srst) gap <= 1000;
    else if ($changed(voltage_code[0])) gap <= 1;
    else if (gap < 1000) gap <= gap + 1;
  end
  a_ready_setup: assert property (psel && !penable |=> pready && $past(psel))
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_err_unmapped: assert property (psel && pready && paddr > bsdc_pkg::OFS_LIN_EN |-> pslverr)
    else $error("unmapped access not refused");
  a_forced_path: assert property (ctrl_wr |-> ##[1:3] conv_clk_from_sync == ctrl_w[9:5])
    else $error("clock path does not follow mode");
  a_sink_follow: assert property (ctrl_wr |-> ##[1:3] sink_limit_enable == ctrl_w[10])
    else $error("sink limit does not follow control");
  a_period_clamp: assert property (sw_period >= bsdc_pkg::SAT_HI_CYC &&
    sw_period <= bsdc_pkg::SAT_LO_CYC) else $error("switching period out of range");
  a_monitor_code: assert property (load_monitor_select <= 3'h5)
    else $error("monitor code out of range");
  a_monitor_forced: assert property ($rose(|load_monitor_select) |-> |conv_clk_from_sync)
    else $error("monitor routed without forced mode");
  a_irq_rail_off: assert property ($rose(short_irq) |->
    ($past(conv_on) & ~conv_on) != 5'h00 || ($past(lin_on) & ~lin_on) != 5'h00)
    else $error("short interrupt without rail shutdown");
  a_short_qual: assert property ($rose(short_irq) |-> run >= QUAL_CYC)
    else $error("short flagged before qualification");
  a_ramp_unit: assert property ($changed(voltage_code[0]) |->
    voltage_code[0] == $past(voltage_code[0]) + 7'h01 ||
    voltage_code[0] + 7'h01 == $past(voltage_code[0])) else $error("ramp step not one code");
  a_ramp_rate: assert property ($changed(voltage_code[0]) |->
    gap >= bsdc_pkg::RAMP_STEP_CYC - 1) else $error("ramp steps too close");
  c_short: cover property ($rose(short_irq));
  c_err: cover property (pready && pslverr);
  c_step: cover property ($changed(voltage_code[0]));
  c_good: cover property ($fell(rails_good));
endmodule : bsdc_monitor

bind bsdc_top bsdc_monitor #(.QUAL_CYC(QUAL_CYC)) bsdc_monitor_i (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .sense(sense),
  .conv_on(conv_on), .lin_on(lin_on), .conv_clk_from_sync(conv_clk_from_sync),
  .sw_period(sw_period), .sink_limit_enable(sink_limit_enable),
  .load_monitor_select(load_monitor_select), .rails_good(rails_good),
  .short_irq(short_irq), .voltage_code(voltage_code));

// >>> dv/bsdc_top_tb.sv
// Purpose: self-checking bench for buck supervision and voltage select
// Assumes: shortened qualification and startup counts, zero-wait APB slave
// Notes: analog sense levels driven directly, sync clock from the source model
module bsdc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QC = 20;
  localparam int RS = bsdc_pkg::RAMP_STEP_CYC;
  localparam logic [31:0] CR = bsdc_pkg::CTRL_RST;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sleep_pin = 1'b0;
  logic pin_a = 1'b0;
  logic pin_b = 1'b0;
  logic dual_phase = 1'b0;
  logic [7:0] half = 8'h00;
  bsdc_pkg::bsdc_sense_t sense = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, sync_clk, sync_locked, sink_limit_enable, rails_good, short_irq;
  logic [4:0] conv_on, lin_on, conv_clk_from_sync;
  logic [7:0] sw_period;
  logic [2:0] load_monitor_select;
  logic [2:0][6:0] voltage_code;
  logic [7:0] hp [4] = '{8'h0f, 8'h28, 8'h19, 8'h00};
  logic [7:0] ep [4] = '{bsdc_pkg::SAT_HI_CYC, bsdc_pkg::SAT_LO_CYC, 8'h32,
    bsdc_pkg::FALLBACK_CYC};
  int bad_count = 0;
  int total_checks = 0;

  // 100 MHz system clock
  always #5 clk = ~clk;

  bsdc_top #(.QUAL_CYC(QC), .MASK_CYC(50)) bsdc_top_i (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense(sense), .switch_sync_clock_in(sync_clk), .sleep_request_pin(sleep_pin),
    .rail_enable_pin_a(pin_a), .rail_enable_pin_b(pin_b), .dual_phase(dual_phase),
    .conv_on(conv_on), .lin_on(lin_on), .conv_clk_from_sync(conv_clk_from_sync),
    .sw_period(sw_period), .sync_locked(sync_locked), .sink_limit_enable(sink_limit_enable),
    .load_monitor_select(load_monitor_select), .rails_good(rails_good),
    .short_irq(short_irq), .voltage_code(voltage_code));
  bsdc_sync_src bsdc_sync_src_i (.clk(clk), .half(half), .sync_clk(sync_clk));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rchk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // Hang guard, far beyond the seven thousand or so cycles the run needs
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end

  // Main sequence
  initial begin
    sense.conv_vgood = 5'h1f;
    sense.conv_igood = 5'h1f;
    sense.thermal = 5'h05;
    sense.device_enable = 1'b1;
    cyc(2);
    srst <= 1'b0;
    cyc(1);
    chk("sink", 32'h1, sink_limit_enable);
    rchk(bsdc_pkg::OFS_CTRL, CR);
    rchk(bsdc_pkg::OFS_PG_MASK, 32'(bsdc_pkg::PG_MASK_RST));
    rchk(bsdc_pkg::OFS_THERMAL, 32'h5);
    rchk(8'h40, 32'h0);
    chk("slverr", 32'h1, er);
    wr(bsdc_pkg::OFS_CTRL, 32'h2000);
    cyc(3);
    chk("sink", 32'h0, sink_limit_enable);
    rchk(bsdc_pkg::OFS_THERMAL, 32'h0);
    wr(bsdc_pkg::OFS_CTRL, CR | 32'h3e0);
    for (int c = 1; c <= 5; c++) begin
      wr(bsdc_pkg::OFS_MON_SEL, 32'(c));
      cyc(3);
      chk("monitor", 32'(c), load_monitor_select);
    end
    chk("forced", 32'h1f, conv_clk_from_sync);
    wr(bsdc_pkg::OFS_CTRL, CR);
    cyc(3);
    chk("forced", 32'h0, conv_clk_from_sync);
    chk("monitor", 32'h0, load_monitor_select);
    for (int i = 0; i < 4; i++) begin
      half <= hp[i];
      cyc(600);
      chk("period", ep[i], sw_period);
    end
    chk("locked", 32'h0, sync_locked);
    // Converter short: too brief, then qualified, then read clear
    wr(bsdc_pkg::OFS_CTRL, CR | 32'h8);
    cyc(80);
    sense.conv_short[3] <= 1'b1;
    cyc(QC / 2);
    sense.conv_short[3] <= 1'b0;
    cyc(30);
    chk("rails", 32'h8, conv_on);
    sense.conv_short[3] <= 1'b1;
    cyc(QC + 10);
    sense.conv_short[3] <= 1'b0;
    chk("rails", 32'h0, conv_on);
    chk("irq", 32'h1, short_irq);
    cyc(20);
    chk("rails", 32'h0, conv_on);
    rchk(bsdc_pkg::OFS_CONV_SHORT, 32'h8);
    rchk(bsdc_pkg::OFS_CONV_SHORT, 32'h0);
    chk("irq", 32'h0, short_irq);
    chk("rails", 32'h8, conv_on);
    // Linear short with interrupt masked, then a short inside the startup mask
    wr(bsdc_pkg::OFS_CTRL, CR | 32'h1000);
    wr(bsdc_pkg::OFS_LIN_EN, 32'h1);
    cyc(80);
    sense.lin_short[0] <= 1'b1;
    cyc(QC + 10);
    sense.lin_short[0] <= 1'b0;
    chk("linear", 32'h0, lin_on);
    chk("irq", 32'h0, short_irq);
    rchk(bsdc_pkg::OFS_LIN_SHORT, 32'h1);
    wr(bsdc_pkg::OFS_LIN_EN, 32'h3);
    rchk(bsdc_pkg::OFS_STATUS, 32'h5);
    sense.lin_short[1] <= 1'b1;
    cyc(QC + 10);
    sense.lin_short[1] <= 1'b0;
    chk("linear", 32'h3, lin_on);
    rchk(bsdc_pkg::OFS_LIN_SHORT, 32'h0);
    // Rails-good selection, masking, compare mode and dual phase
    wr(bsdc_pkg::OFS_CTRL, CR);
    cyc(10);
    chk("good", 32'h1, rails_good);
    sense.conv_vgood[0] <= 1'b0;
    cyc(10);
    chk("good", 32'h0, rails_good);
    wr(bsdc_pkg::OFS_CTRL, CR & ~32'h2000);
    cyc(10);
    chk("good", 32'h1, rails_good);
    rchk(bsdc_pkg::OFS_STATUS, 32'h1);
    sense.conv_igood[0] <= 1'b0;
    cyc(10);
    chk("good", 32'h0, rails_good);
    wr(bsdc_pkg::OFS_PG_MASK, 32'h1f);
    cyc(10);
    chk("good", 32'h1, rails_good);
    sense.conv_igood[0] <= 1'b1;
    sense.conv_vgood[0] <= 1'b1;
    sense.adc_over_limit <= 1'b1;
    wr(bsdc_pkg::OFS_PG_MASK, 32'h1e);
    wr(bsdc_pkg::OFS_CTRL, CR | 32'h4020);
    wr(bsdc_pkg::OFS_MON_SEL, 32'h1);
    cyc(10);
    chk("good", 32'h0, rails_good);
    sense.adc_over_limit <= 1'b0;
    sense.conv_igood[1] <= 1'b0;
    // Dual phase now takes rail 1 out of the rails-good check
    dual_phase <= 1'b1;
    wr(bsdc_pkg::OFS_PG_MASK, 32'h1d);
    cyc(10);
    chk("good", 32'h1, rails_good);
    dual_phase <= 1'b0;
    cyc(10);
    chk("good", 32'h0, rails_good);
    // Roof and floor on rail 0, then the command bit
    wr(bsdc_pkg::OFS_PG_MASK, 32'h1e);
    wr(bsdc_pkg::OFS_PRIMARY0, 32'h3);
    wr(bsdc_pkg::OFS_SECONDARY0, 32'h2);
    wr(bsdc_pkg::OFS_RAIL_MAP, 32'h1);
    wr(bsdc_pkg::OFS_DVS_CTRL, 32'h1);
    wr(bsdc_pkg::OFS_CTRL, CR | 32'h21);
    sleep_pin <= 1'b1;
    sense.conv_vgood[0] <= 1'b0;
    cyc(RS);
    chk("good", 32'h1, rails_good);
    cyc(2 * RS + 100);
    chk("code", 32'h3, voltage_code[0]);
    chk("good", 32'h0, rails_good);
    sense.conv_vgood[0] <= 1'b1;
    sleep_pin <= 1'b0;
    cyc(RS + 50);
    chk("code", 32'h2, voltage_code[0]);
    wr(bsdc_pkg::OFS_SECONDARY0, 32'h0);
    cyc(5);
    chk("rails", 32'h0, conv_on);
    sleep_pin <= 1'b1;
    cyc(5);
    chk("rails", 32'h1, conv_on);
    wr(bsdc_pkg::OFS_RAIL_MAP, 32'h0001_0100);
    cyc(5);
    chk("rails", 32'h0, conv_on);
    pin_a <= 1'b1;
    cyc(5);
    chk("rails", 32'h1, conv_on);
    pin_a <= 1'b0;
    pin_b <= 1'b1;
    cyc(5);
    chk("rails", 32'h1, conv_on);
    wr(bsdc_pkg::OFS_DVS_CTRL, 32'h0);
    wr(bsdc_pkg::OFS_SECONDARY0, 32'h81);
    rchk(bsdc_pkg::OFS_SECONDARY0, 32'h81);
    cyc(3 * RS);
    chk("code", 32'h1, voltage_code[0]);
    wr(bsdc_pkg::OFS_SECONDARY0, 32'h1);
    cyc(3 * RS);
    chk("code", 32'h3, voltage_code[0]);
    end_of_test();
  end
endmodule : bsdc_top_tb
